/* logic/usrx_top.sv */
// synchronous serial port: master/slave reception and transmission
// assumes an axi4-lite master on clk_sys and pin buffers outside
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module usrx_top
    import usrx_pkg::*;
(
    // system
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // axi4-lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // shift clock pin
    input wire logic shift_clock_pin_i,
    output logic shift_clock_pin_o,
    output logic shift_clock_pin_oe,
    // data pin
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe,
    // requests to the interrupt controller
    output logic receive_irq,
    output logic transmit_irq,
    output logic wake_req
);

    usrx_state_t st_reg;
    usrx_state_t st_next;
    usrx_bus_t bus_reg;
    usrx_bus_t bus_next;
    logic ck_s1_reg;
    logic ck_s2_reg;
    logic dt_s1_reg;
    logic dt_s2_reg;
    logic wr_fire;
    logic rd_fire;
    logic wr_mapped;
    logic rd_rx_data;
    logic [7:0] rd_value;
    logic [15:0] divisor;
    logic rx_en;
    logic tx_go;
    logic m_run;
    logic m_tick;
    logic slave_level;
    logic rise;
    logic fall;
    logic rc_set;
    logic [7:0] wd;

    // pin synchronisers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ck_s1_reg <= 1'b0;
            ck_s2_reg <= 1'b0;
            dt_s1_reg <= 1'b0;
            dt_s2_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            ck_s1_reg <= shift_clock_pin_i;
            ck_s2_reg <= ck_s1_reg;
            dt_s1_reg <= serial_data_pin_i;
            dt_s2_reg <= dt_s1_reg;
        end
    end

    // register read view
    always_comb
    begin
        rd_value = 8'h00;
        unique case ({s_axi_araddr[5:2], 2'b00})
            OFS_RX_STATUS:
            begin
                rd_value[B_SERIAL_PORT_ENABLE] = st_reg.serial_port_enable;
                rd_value[B_NINE_BIT_RX] = st_reg.nine_bit_receive_select;
                rd_value[B_SINGLE_RX] = st_reg.single_receive_enable;
                rd_value[B_CONT_RX] = st_reg.continuous_receive_enable;
                // no stop bit in synchronous frames: framing never fails
                rd_value[B_FRAMING_ERROR] = 1'b0;
                rd_value[B_OVERRUN_ERROR] = st_reg.overrun_error;
                rd_value[B_RX_NINTH] = st_reg.received_ninth_bit;
            end
            OFS_RX_DATA: rd_value = st_reg.receive_data_buffer;
            OFS_TX_STATUS:
            begin
                rd_value[B_CLOCK_SOURCE] = st_reg.clock_source_select;
                rd_value[B_NINE_BIT_TX] = st_reg.nine_bit_transmit_select;
                rd_value[B_TX_ENABLE] = st_reg.transmit_enable;
                rd_value[B_SYNC_MODE] = st_reg.sync_mode_select;
                rd_value[B_HIGH_RATE] = st_reg.high_rate_select;
                rd_value[B_SHIFT_EMPTY] = ~st_reg.tx_busy;
                rd_value[B_TX_NINTH] = st_reg.transmit_ninth_bit;
            end
            OFS_BAUD_CTRL:
            begin
                rd_value[B_IDLE_POLARITY] = st_reg.clock_idle_polarity;
                rd_value[B_WIDE_BAUD] = st_reg.wide_baud_generator_select;
            end
            OFS_DIV_HIGH: rd_value = st_reg.baud_divisor_high;
            OFS_DIV_LOW: rd_value = st_reg.baud_divisor_low;
            OFS_TX_DATA: rd_value = st_reg.transmit_data_buffer;
            OFS_IRQ:
            begin
                rd_value[B_RX_FLAG] = st_reg.receive_complete_flag;
                rd_value[B_TX_FLAG] = ~st_reg.tx_buf_full;
                rd_value[B_RX_IRQ_EN] = st_reg.receive_irq_enable;
                rd_value[B_TX_IRQ_EN] = st_reg.transmit_irq_enable;
            end
            default: rd_value = 8'h00;
        endcase
    end

    // bus slave: address and data are held until both are in
    assign wr_fire = bus_reg.aw_hold & bus_reg.w_hold & ~bus_reg.bvalid;
    assign rd_fire = s_axi_arvalid & ~bus_reg.rvalid;
    assign wr_mapped = ~bus_reg.aw_addr[5];
    assign rd_rx_data = rd_fire
        & ({s_axi_araddr[5:2], 2'b00} == OFS_RX_DATA);

    always_comb
    begin
        bus_next = bus_reg;
        if (s_axi_awvalid & ~bus_reg.aw_hold)
        begin
            bus_next.aw_hold = 1'b1;
            bus_next.aw_addr = {s_axi_awaddr[5:2], 2'b00};
        end
        if (s_axi_wvalid & ~bus_reg.w_hold)
        begin
            bus_next.w_hold = 1'b1;
            bus_next.w_data = s_axi_wdata[7:0];
            bus_next.w_lane0 = s_axi_wstrb[0];
        end
        if (wr_fire)
        begin
            bus_next.aw_hold = 1'b0;
            bus_next.w_hold = 1'b0;
            bus_next.bvalid = 1'b1;
            bus_next.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bus_reg.bvalid & s_axi_bready)
        begin
            bus_next.bvalid = 1'b0;
        end
        if (rd_fire)
        begin
            bus_next.rvalid = 1'b1;
            bus_next.rdata = rd_value;
            bus_next.rresp = s_axi_araddr[5] ? RESP_SLVERR : RESP_OKAY;
        end
        else if (bus_reg.rvalid & s_axi_rready)
        begin
            bus_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            bus_reg <= BUS_RST;
        end
        else if (clk_en)
        begin
            bus_reg <= bus_next;
        end
    end

    assign s_axi_awready = ~bus_reg.aw_hold;
    assign s_axi_wready = ~bus_reg.w_hold;
    assign s_axi_bvalid = bus_reg.bvalid;
    assign s_axi_bresp = bus_reg.bresp;
    assign s_axi_arready = ~bus_reg.rvalid;
    assign s_axi_rvalid = bus_reg.rvalid;
    assign s_axi_rdata = {24'h00_0000, bus_reg.rdata};
    assign s_axi_rresp = bus_reg.rresp;

    // shift clock timing
    assign divisor = st_reg.wide_baud_generator_select
        ? {st_reg.baud_divisor_high, st_reg.baud_divisor_low}
        : {8'h00, st_reg.baud_divisor_low};
    // single enable only counts when this end makes the clock
    assign rx_en = st_reg.serial_port_enable & st_reg.sync_mode_select
        & ~st_reg.overrun_error
        & (st_reg.continuous_receive_enable
        | (st_reg.single_receive_enable & st_reg.clock_source_select));
    // half duplex: an enabled receiver silences the transmitter
    assign tx_go = st_reg.serial_port_enable & st_reg.sync_mode_select
        & st_reg.transmit_enable & ~rx_en;
    assign m_run = st_reg.serial_port_enable & st_reg.sync_mode_select
        & st_reg.clock_source_select & (rx_en | st_reg.tx_busy);
    assign m_tick = m_run & (st_reg.brg_count == divisor);
    assign slave_level = ck_s2_reg ^ st_reg.clock_idle_polarity;
    always_comb
    begin
        if (st_reg.clock_source_select)
        begin
            rise = m_tick & ~st_reg.ck_level;
            fall = m_tick & st_reg.ck_level;
        end
        else
        begin
            rise = slave_level & ~st_reg.ck_slave_prev;
            fall = ~slave_level & st_reg.ck_slave_prev;
        end
    end

    assign wd = bus_reg.w_data;

    always_comb
    begin
        st_next = st_reg;
        rc_set = 1'b0;
        st_next.ck_slave_prev = slave_level;

        // baud generator, idle level whenever nothing is shifting
        if (!m_run)
        begin
            st_next.brg_count = 16'h0000;
            st_next.ck_level = 1'b0;
        end
        else if (m_tick)
        begin
            st_next.brg_count = 16'h0000;
            st_next.ck_level = ~st_reg.ck_level;
        end
        else
        begin
            st_next.brg_count = st_reg.brg_count + 16'h0001;
        end

        // receiver; disabling mid-word drops the partial word
        if (!rx_en)
        begin
            st_next.rx_bits = 4'h0;
        end
        else if (fall)
        begin
            st_next.rx_shift = {dt_s2_reg, st_reg.rx_shift[8:1]};
            if (st_reg.rx_bits == (st_reg.nine_bit_receive_select
                ? LAST_BIT_9 : LAST_BIT_8))
            begin
                st_next.rx_bits = 4'h0;
                if (st_reg.receive_complete_flag & ~rd_rx_data)
                begin
                    // unread word kept, new one lost
                    st_next.overrun_error = 1'b1;
                end
                else if (st_reg.nine_bit_receive_select)
                begin
                    st_next.receive_data_buffer = st_next.rx_shift[7:0];
                    st_next.received_ninth_bit = st_next.rx_shift[8];
                    rc_set = 1'b1;
                end
                else
                begin
                    st_next.receive_data_buffer = st_next.rx_shift[8:1];
                    st_next.received_ninth_bit = 1'b0;
                    rc_set = 1'b1;
                end
                if (!st_reg.continuous_receive_enable)
                begin
                    st_next.single_receive_enable = 1'b0;
                end
            end
            else
            begin
                st_next.rx_bits = st_reg.rx_bits + 4'h1;
            end
        end

        // transmitter, buffer moves to shifter only when it is empty
        if (!tx_go)
        begin
            st_next.tx_busy = 1'b0;
        end
        else if (st_reg.tx_busy)
        begin
            if (fall)
            begin
                st_next.transmit_shift_register =
                    {1'b1, st_reg.transmit_shift_register[8:1]};
                if (st_reg.tx_bits == (st_reg.nine_bit_transmit_select
                    ? LAST_BIT_9 : LAST_BIT_8))
                begin
                    st_next.tx_busy = 1'b0;
                end
                else
                begin
                    st_next.tx_bits = st_reg.tx_bits + 4'h1;
                end
            end
        end
        else if (st_reg.tx_buf_full)
        begin
            st_next.transmit_shift_register =
                {st_reg.tx_buf_ninth, st_reg.transmit_data_buffer};
            st_next.tx_busy = 1'b1;
            st_next.tx_bits = 4'h0;
            st_next.tx_buf_full = 1'b0;
        end

        // software writes
        if (wr_fire & bus_reg.w_lane0)
        begin
            unique case (bus_reg.aw_addr)
                OFS_RX_STATUS:
                begin
                    st_next.serial_port_enable = wd[B_SERIAL_PORT_ENABLE];
                    st_next.nine_bit_receive_select = wd[B_NINE_BIT_RX];
                    st_next.single_receive_enable = wd[B_SINGLE_RX];
                    st_next.continuous_receive_enable = wd[B_CONT_RX];
                    // an overrun raised in this very cycle wins over the clear
                    if (!wd[B_CONT_RX]
                        && !(st_next.overrun_error && !st_reg.overrun_error))
                    begin
                        st_next.overrun_error = 1'b0;
                    end
                end
                OFS_TX_STATUS:
                begin
                    st_next.clock_source_select = wd[B_CLOCK_SOURCE];
                    st_next.nine_bit_transmit_select = wd[B_NINE_BIT_TX];
                    st_next.transmit_enable = wd[B_TX_ENABLE];
                    st_next.sync_mode_select = wd[B_SYNC_MODE];
                    st_next.high_rate_select = wd[B_HIGH_RATE];
                    st_next.transmit_ninth_bit = wd[B_TX_NINTH];
                end
                OFS_BAUD_CTRL:
                begin
                    st_next.clock_idle_polarity = wd[B_IDLE_POLARITY];
                    st_next.wide_baud_generator_select = wd[B_WIDE_BAUD];
                end
                OFS_DIV_HIGH: st_next.baud_divisor_high = wd;
                OFS_DIV_LOW: st_next.baud_divisor_low = wd;
                OFS_TX_DATA:
                begin
                    st_next.transmit_data_buffer = wd;
                    st_next.tx_buf_ninth = st_reg.transmit_ninth_bit;
                    st_next.tx_buf_full = 1'b1;
                end
                OFS_IRQ:
                begin
                    st_next.receive_irq_enable = wd[B_RX_IRQ_EN];
                    st_next.transmit_irq_enable = wd[B_TX_IRQ_EN];
                end
                default:
                begin
                end
            endcase
        end

        // reading the data clears the flag; a new word in that cycle wins
        if (rd_rx_data)
        begin
            st_next.receive_complete_flag = 1'b0;
        end
        if (rc_set)
        begin
            st_next.receive_complete_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_reg <= STATE_RST;
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    // pins
    assign shift_clock_pin_oe = st_reg.serial_port_enable
        & st_reg.sync_mode_select & st_reg.clock_source_select;
    assign shift_clock_pin_o = st_reg.ck_level
        ^ st_reg.clock_idle_polarity;
    assign serial_data_pin_o = st_reg.transmit_shift_register[0];
    assign serial_data_pin_oe = tx_go;

    // interrupt requests; the shift-empty bit has none
    assign receive_irq = st_reg.receive_complete_flag
        & st_reg.receive_irq_enable;
    assign transmit_irq = ~st_reg.tx_buf_full
        & st_reg.transmit_irq_enable;
    assign wake_req = receive_irq | transmit_irq;

endmodule : usrx_top

`default_nettype wire

/* logic/usrx_pkg.sv */
// constants, register map and state types of the synchronous serial block
// assumes an axi4-lite master with 32-bit data and 6-bit byte addresses
package usrx_pkg;

    localparam int AXI_ADDR_W = 6;

    // byte offsets, one aligned word each
    localparam logic [5:0] OFS_RX_STATUS = 6'h00;
    localparam logic [5:0] OFS_RX_DATA = 6'h04;
    localparam logic [5:0] OFS_TX_STATUS = 6'h08;
    localparam logic [5:0] OFS_BAUD_CTRL = 6'h0C;
    localparam logic [5:0] OFS_DIV_HIGH = 6'h10;
    localparam logic [5:0] OFS_DIV_LOW = 6'h14;
    localparam logic [5:0] OFS_TX_DATA = 6'h18;
    localparam logic [5:0] OFS_IRQ = 6'h1C;

    // receive_status_control fields
    localparam int B_SERIAL_PORT_ENABLE = 7;
    localparam int B_NINE_BIT_RX = 6;
    localparam int B_SINGLE_RX = 5;
    localparam int B_CONT_RX = 4;
    localparam int B_FRAMING_ERROR = 2;
    localparam int B_OVERRUN_ERROR = 1;
    localparam int B_RX_NINTH = 0;
    // transmit_status_control fields
    localparam int B_CLOCK_SOURCE = 7;
    localparam int B_NINE_BIT_TX = 6;
    localparam int B_TX_ENABLE = 5;
    localparam int B_SYNC_MODE = 4;
    localparam int B_HIGH_RATE = 2;
    localparam int B_SHIFT_EMPTY = 1;
    localparam int B_TX_NINTH = 0;
    // baud_control fields
    localparam int B_IDLE_POLARITY = 4;
    localparam int B_WIDE_BAUD = 3;
    // interrupt flag and enable register fields
    localparam int B_RX_FLAG = 0;
    localparam int B_TX_FLAG = 1;
    localparam int B_RX_IRQ_EN = 4;
    localparam int B_TX_IRQ_EN = 5;

    // index of the last bit of a word
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic serial_port_enable;
        logic nine_bit_receive_select;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic overrun_error;
        logic received_ninth_bit;
        logic clock_source_select;
        logic nine_bit_transmit_select;
        logic transmit_enable;
        logic sync_mode_select;
        logic high_rate_select;
        logic transmit_ninth_bit;
        logic clock_idle_polarity;
        logic wide_baud_generator_select;
        logic [7:0] baud_divisor_high;
        logic [7:0] baud_divisor_low;
        logic receive_irq_enable;
        logic transmit_irq_enable;
        logic receive_complete_flag;
        logic [7:0] receive_data_buffer;
        logic [7:0] transmit_data_buffer;
        logic tx_buf_ninth;
        logic tx_buf_full;
        logic [8:0] transmit_shift_register;
        logic [8:0] rx_shift;
        logic tx_busy;
        logic [3:0] tx_bits;
        logic [3:0] rx_bits;
        logic [15:0] brg_count;
        logic ck_level;
        logic ck_slave_prev;
    } usrx_state_t;

    typedef struct packed {
        logic aw_hold;
        logic [5:0] aw_addr;
        logic w_hold;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } usrx_bus_t;

    localparam usrx_state_t STATE_RST = '0;
    localparam usrx_bus_t BUS_RST = '0;

endpackage : usrx_pkg

/* verification/usrx_top_sva.sv */
// concurrent checks on the bus and request ports of usrx_top
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module usrx_checker
    import usrx_pkg::*;
(
    // system
    input wire logic clk_sys,
    input wire logic rst_n,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // requests
    input wire logic receive_irq,
    input wire logic transmit_irq,
    input wire logic wake_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && !s_axi_bvalid;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_b_time;
        s_wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    property p_b_drop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_aw_hold;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    property p_r_time;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    property p_r_drop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    property p_ar_ready;
        s_axi_arready != s_axi_rvalid;
    endproperty
    property p_r_upper;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
    endproperty
    property p_slverr;
        s_rd_take ##0 s_axi_araddr[5]
            |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
    endproperty
    property p_wake;
        wake_req == (receive_irq || transmit_irq);
    endproperty
    a_b_time: assert property (p_b_time) else $error("late write answer");
    a_b_drop: assert property (p_b_drop) else $error("bvalid stuck");
    a_aw_hold: assert property (p_aw_hold) else $error("awready early");
    a_r_time: assert property (p_r_time) else $error("late read answer");
    a_r_drop: assert property (p_r_drop) else $error("rvalid stuck");
    a_ar_ready: assert property (p_ar_ready) else $error("arready wrong");
    a_r_upper: assert property (p_r_upper) else $error("rdata upper set");
    a_slverr: assert property (p_slverr) else $error("no slave error");
    a_wake: assert property (p_wake) else $error("wake wrong");
endmodule : usrx_checker
bind usrx_top usrx_checker u_usrx_checker (.clk_sys, .rst_n,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .receive_irq, .transmit_irq, .wake_req);
`default_nettype wire

/* verification/usrx_partner.sv */
// behavioural serial partner on the shift clock and data lines
// assumes the bench resolves each line from both drivers
`timescale 1ns/1ns
`default_nettype none
module usrx_partner
(
    // lines as resolved by the bench, and the design's clock output enable
    input wire logic ck_line,
    input wire logic ck_master,
    input wire logic dt_line,
    // partner drive
    output logic ck_drv,
    output logic dt_drv
);
    logic [7:0] word_reg = 8'h00;
    initial ck_drv = 1'b0;
    assign dt_drv = word_reg[0];
    // change only after the falling edge that the receiver samples on
    always @(negedge ck_line)
        if (ck_master)
            word_reg <= {word_reg[0], word_reg[7:1]};
    task automatic load(input logic [7:0] d);
        word_reg = d;
    endtask : load
    // clock stands low between words; data taken late in the high phase
    task automatic clock_word(input int n, output logic [8:0] got);
        got = 9'h000;
        for (int i = 0; i < n; i++)
        begin
            ck_drv = 1'b1;
            #390 got[i] = dt_line;
            #10 ck_drv = 1'b0;
            #400;
        end
    endtask : clock_word
endmodule : usrx_partner
`default_nettype wire

/* verification/usrx_top_bench.sv */
// self-checking bench for usrx_top with the serial partner model
// assumes the checker is bound into the design top
`timescale 1ns/1ns
`default_nettype none
module usrx_top_bench import usrx_pkg::*;;
    logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic ck_o, ck_oe, dt_o, dt_oe, ck_drv, dt_drv;
    logic receive_irq, transmit_irq, wake_req;
    logic [7:0] b, a, c;
    logic [8:0] got;
    int errors = 0, num_checks = 0;
    wire logic ck_line = ck_oe ? ck_o : ck_drv;
    wire logic dt_line = dt_oe ? dt_o : dt_drv;
    always #50 clk_sys = ~clk_sys;
    usrx_top u_usrx_top (.clk_sys, .rst_n, .clk_en, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .shift_clock_pin_i(ck_line), .shift_clock_pin_o(ck_o),
        .shift_clock_pin_oe(ck_oe), .serial_data_pin_i(dt_line),
        .serial_data_pin_o(dt_o), .serial_data_pin_oe(dt_oe),
        .receive_irq, .transmit_irq, .wake_req);
    usrx_partner u_usrx_partner (.ck_line, .ck_master(ck_oe), .dt_line,
        .ck_drv, .dt_drv);
    function automatic logic [8:0] frame9(input logic [7:0] d);
        return {1'b1, d};
    endfunction : frame9
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // handshakes are judged on values settled at the falling edge
    task automatic wr(input logic [5:0] ad, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge clk_sys);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= ad;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= 4'hf;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge clk_sys);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge clk_sys);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
        end
        while (tb !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] ad);
        logic ta, tr;
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= ad;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge clk_sys);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys);
            if (ta)
                s_axi_arvalid <= 1'b0;
        end
        while (tr !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wait_rx;
        int n;
        n = 0;
        while (receive_irq !== 1'b1 && n < 3000)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk("receive_irq", 32'h0000_0001, receive_irq);
    endtask : wait_rx
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #3_000_000;
        errors++;
        tally_and_finish();
    end
    initial
    begin
        void'($urandom(32'h7727));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(OFS_TX_STATUS);
        chk("tx_status", 32'h0000_0002, v);
        rd(OFS_IRQ);
        chk("irq_reg", 32'h0000_0002, v);
        rd(6'h20);
        chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
        $display("test reset done");
        wr(OFS_DIV_LOW, 8'h03);
        wr(OFS_TX_STATUS, 8'h90);
        wr(OFS_IRQ, 8'h10);
        for (int m = 0; m < 2; m++)
        begin
            b = $urandom;
            u_usrx_partner.load(b);
            wr(OFS_RX_STATUS, m ? 8'hb0 : 8'ha0);
            repeat (m + 1)
            begin
                wait_rx();
                rd(OFS_RX_DATA);
                chk("rx_data", {24'h00_0000, b}, v);
            end
            rd(OFS_RX_STATUS);
            chk("rx_status", m ? 32'h0000_00b0 : 32'h0000_0080, v);
        end
        wr(OFS_RX_STATUS, 8'h80);
        repeat (20) @(posedge clk_sys);
        chk("ck_idle_low", 32'h0000_0000, ck_o);
        wr(OFS_BAUD_CTRL, 8'h10);
        repeat (2) @(posedge clk_sys);
        chk("ck_idle_high", 32'h0000_0001, ck_o);
        wr(OFS_BAUD_CTRL, 8'h00);
        $display("test master receive done");
        wr(OFS_RX_STATUS, 8'h90);
        wait_rx();
        repeat (200) @(posedge clk_sys);
        rd(OFS_RX_STATUS);
        chk("overrun", 32'h0000_0092, v);
        wr(OFS_RX_STATUS, 8'h80);
        rd(OFS_RX_STATUS);
        chk("error_cleared", 32'h0000_0080, v);
        rd(OFS_RX_DATA);
        $display("test overrun done");
        wr(OFS_TX_STATUS, 8'h71);
        wr(OFS_IRQ, 8'h20);
        chk("dt_oe", 32'h0000_0001, dt_oe);
        chk("ck_oe", 32'h0000_0000, ck_oe);
        a = $urandom;
        c = $urandom;
        wr(OFS_TX_DATA, a);
        wr(OFS_TX_DATA, c);
        rd(OFS_IRQ);
        chk("flag_held", 32'h0000_0020, v);
        u_usrx_partner.clock_word(9, got);
        chk("tx_word0", frame9(a), got);
        repeat (5) @(posedge clk_sys);
        chk("wake_req", 32'h0000_0001, wake_req);
        u_usrx_partner.clock_word(9, got);
        chk("tx_word1", frame9(c), got);
        repeat (5) @(posedge clk_sys);
        rd(OFS_TX_STATUS);
        chk("tx_done", 32'h0000_0073, v);
        wr(OFS_IRQ, 8'h20);
        rd(OFS_IRQ);
        chk("flag_kept", 32'h0000_0022, v);
        $display("test slave transmit done");
        tally_and_finish();
    end
endmodule : usrx_top_bench
`default_nettype wire
